// ===== cspc_pkg.sv
// Functional notes
// - Switching and monitor only when config bit 0.
// - Disabled: current source follows initial configuration.
// - Disabled: switch request ignored, reads zero.
// - Same source requested: clear request, abort.
// - Valid switch clears lock and fail flags.
// - Start new oscillator; await startup timer, lock.
// - Count ten new-clock cycles before changeover.
// - Done: clear request, copy requested to current.
// - Stop old oscillator, keep RC if needed.
// - CPU keeps running while switching.
// - Primary submode fixed after reset.
// - Monitor on: low-power RC runs except sleep.
// - Failure: raise trap, fall back to internal RC.
// - Failure with PLL: fallback keeps PLL.
// - Sleep stops clocks, monitor and peripherals.
// - Sleep clears watchdog; RC runs if enabled.
// - Wake on interrupt, reset, watchdog; same source.
// - Idle stops CPU, clears watchdog, clock runs.
// - Idle wake restores CPU clock at once.
// - Interrupt during entry wakes after entry.
// - Monitor sets fail flag; software reads, clears.
// - Request bit one starts; zero means finished.
package cspc_pkg;

   // ==========================================================
   // Bus and register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OSC_CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] PWR_CTRL_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] PWR_STAT_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] CFG_STAT_OFS = 8'h0C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Field positions
   localparam int CUR_SRC_LSB = 12;
   localparam int REQ_SRC_LSB = 8;
   localparam int LOCK_BIT = 5;
   localparam int CF_BIT = 3;
   localparam int SWREQ_BIT = 0;
   localparam int SLEEP_BIT = 0;
   localparam int IDLE_BIT = 1;

   // ==========================================================
   // Clock source codes
   localparam logic [2:0] SRC_FRC = 3'h0;
   localparam logic [2:0] SRC_INTERNAL_RC_WITH_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI = 3'h2;
   localparam logic [2:0] SRC_PRIPLL = 3'h3;
   localparam logic [2:0] SRC_SEC = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
   localparam logic [1:0] PSUB_EXT = 2'h0;

   // Oscillator index in enables and synchroniser bank
   localparam int OSC_FRC = 0;
   localparam int OSC_PRI = 1;
   localparam int OSC_SEC = 2;
   localparam int OSC_LOW_POWER_RC_OSC = 3;
   localparam int SY_PLL = 4;
   localparam int SY_OST = 5;
   localparam int SYNC_W = 6;

   // ==========================================================
   // Timing counts
   localparam logic [3:0] NEW_CLK_CYCLES = 4'hA;
   localparam logic [3:0] FAIL_LOW_POWER_RC_OSC_TICKS = 4'h3;

   // ==========================================================
   // States
   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_CHECK = 2'b01,
      SW_START = 2'b10,
      SW_COUNT = 2'b11
   } cspc_sw_t;

   typedef enum logic [1:0] {
      PW_RUN = 2'b00,
      PW_SLEEP = 2'b01,
      PW_IDLE = 2'b10
   } cspc_pw_t;

endpackage : cspc_pkg

// ===== cspc_sync.sv
module cspc_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [cspc_pkg::SYNC_W-1:0] async_in,
   output logic [cspc_pkg::SYNC_W-1:0] level,
   output logic [cspc_pkg::SYNC_W-1:0] toggled
);
   import cspc_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
   } cspc_sync_t;

   cspc_sync_t q_r;
   cspc_sync_t q_nxt;

   // ==========================================================
   // Two stages, then a history stage for change detection
   always_comb begin
      q_nxt.s1 = async_in;
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      if (rst) begin
         q_nxt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      q_r <= q_nxt;
   end

   assign level = q_r.s2;
   assign toggled = q_r.s2 ^ q_r.s3;

endmodule : cspc_sync

// ===== cspc_top.sv
module cspc_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [cspc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [cspc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cspc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [cspc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic switch_monitor_cfg,
   input wire logic [2:0] initial_source_cfg,
   input wire logic [1:0] primary_submode_cfg,
   input wire logic wdt_en,
   input wire logic irq_pending,
   input wire logic wdt_timeout,
   input wire logic [3:0] osc_clk_toggle,
   input wire logic pll_lock_pin,
   input wire logic osc_startup_timer_done,
   output logic [2:0] sys_clk_sel,
   output logic [3:0] osc_en,
   output logic pll_en,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic sys_clk_en,
   output logic wdt_clear,
   output logic clk_fail_trap,
   output logic [1:0] primary_submode
);
   import cspc_pkg::*;

   typedef struct packed {
      logic sw_mon_cfg;
      logic [2:0] init_src;
      logic [1:0] psub;
      cspc_sw_t sw;
      cspc_pw_t pw;
      logic [2:0] cur;
      logic [2:0] req;
      logic sw_req;
      logic lock;
      logic cf;
      logic [3:0] cnt;
      logic [3:0] fcnt;
      logic saw;
      logic [3:0] osc_en;
      logic pll_en;
      logic cpu_en;
      logic per_en;
      logic sys_en;
      logic trap;
      logic wdt_clr;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_W-1:0] rdata;
   } cspc_state_t;

   cspc_state_t q_r;
   cspc_state_t q_nxt;
   logic [SYNC_W-1:0] sy_lvl;
   logic [SYNC_W-1:0] sy_tog;
   logic wr_go;
   logic rd_go;
   logic sw_en;
   logic fail_now;
   logic new_edge;
   logic cur_edge;
   logic [DATA_W-1:0] rd_word;
   logic [1:0] rd_resp;

   function automatic logic [3:0] src_osc(input logic [2:0] src);
      logic [3:0] oh;
      oh = 4'h0;
      if (src == SRC_FRC || src == SRC_INTERNAL_RC_WITH_PLL) begin
         oh[OSC_FRC] = 1'b1;
      end else if (src == SRC_PRI || src == SRC_PRIPLL) begin
         oh[OSC_PRI] = 1'b1;
      end else if (src == SRC_SEC) begin
         oh[OSC_SEC] = 1'b1;
      end else begin
         oh[OSC_LOW_POWER_RC_OSC] = 1'b1;
      end
      return oh;
   endfunction : src_osc

   function automatic logic uses_pll(input logic [2:0] src);
      return (src == SRC_INTERNAL_RC_WITH_PLL) || (src == SRC_PRIPLL);
   endfunction : uses_pll

   function automatic logic is_crystal(input logic [2:0] src,
                                       input logic [1:0] sub);
      return (src == SRC_SEC) ||
             ((src == SRC_PRI || src == SRC_PRIPLL) && sub != PSUB_EXT);
   endfunction : is_crystal

   // Oscillator activity, lock and startup timer come from pins
   cspc_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({osc_startup_timer_done, pll_lock_pin, osc_clk_toggle}),
      .level(sy_lvl),
      .toggled(sy_tog)
   );

   // ==========================================================
   // Bus handshakes
   assign sw_en = ~q_r.sw_mon_cfg;
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~q_r.bvalid;
   assign rd_go = s_axi_arvalid & ~q_r.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign new_edge = |(sy_tog[3:0] & src_osc(q_r.req));
   assign cur_edge = |(sy_tog[3:0] & src_osc(q_r.cur));

   // ==========================================================
   // Read mux
   always_comb begin
      rd_word = '0;
      rd_resp = RESP_OKAY;
      if (s_axi_araddr == OSC_CTRL_OFS) begin
         rd_word[CUR_SRC_LSB +: 3] = q_r.cur;
         rd_word[REQ_SRC_LSB +: 3] = q_r.req;
         rd_word[LOCK_BIT] = q_r.lock;
         rd_word[CF_BIT] = q_r.cf;
         rd_word[SWREQ_BIT] = q_r.sw_req;
      end else if (s_axi_araddr == PWR_CTRL_OFS) begin
         rd_word = '0;
      end else if (s_axi_araddr == PWR_STAT_OFS) begin
         rd_word[1:0] = q_r.pw;
         rd_word[3:2] = q_r.sw;
         rd_word[7:4] = q_r.osc_en;
         rd_word[8] = q_r.pll_en;
         rd_word[9] = q_r.cpu_en;
         rd_word[10] = q_r.per_en;
         rd_word[11] = q_r.sys_en;
      end else if (s_axi_araddr == CFG_STAT_OFS) begin
         rd_word[0] = sw_en;
         rd_word[2:1] = q_r.psub;
         rd_word[6:4] = q_r.init_src;
      end else begin
         rd_resp = RESP_SLVERR;
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      q_nxt = q_r;
      q_nxt.trap = 1'b0;
      q_nxt.wdt_clr = 1'b0;
      fail_now = 1'b0;

      // Read and write channels
      if (q_r.bvalid && s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end
      if (q_r.rvalid && s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end
      if (rd_go) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rdata = rd_word;
         q_nxt.rresp = rd_resp;
      end
      if (wr_go) begin
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = RESP_OKAY;
         if (s_axi_awaddr == OSC_CTRL_OFS) begin
            // Source is frozen while a switch is pending
            if (s_axi_wstrb[1] && q_r.sw == SW_IDLE && !q_r.sw_req) begin
               q_nxt.req = s_axi_wdata[REQ_SRC_LSB +: 3];
            end
            if (s_axi_wstrb[0]) begin
               if (s_axi_wdata[SWREQ_BIT] && sw_en && q_r.sw == SW_IDLE) begin
                  q_nxt.sw_req = 1'b1;
               end
               if (!s_axi_wdata[CF_BIT]) begin
                  q_nxt.cf = 1'b0;
               end
            end
         end else if (s_axi_awaddr == PWR_CTRL_OFS) begin
            if (s_axi_wstrb[0] && q_r.pw == PW_RUN) begin
               if (s_axi_wdata[SLEEP_BIT]) begin
                  q_nxt.pw = PW_SLEEP;
                  q_nxt.wdt_clr = wdt_en;
               end else if (s_axi_wdata[IDLE_BIT]) begin
                  q_nxt.pw = PW_IDLE;
                  q_nxt.wdt_clr = wdt_en;
               end
            end
         end else if (s_axi_awaddr == PWR_STAT_OFS ||
                      s_axi_awaddr == CFG_STAT_OFS) begin
            q_nxt.bresp = RESP_OKAY;
         end else begin
            q_nxt.bresp = RESP_SLVERR;
         end
      end

      // Wake is judged only once the state is entered, so a request
      // that races the entry write is held off until after it
      if (q_r.pw != PW_RUN && (irq_pending || wdt_timeout)) begin
         q_nxt.pw = PW_RUN;
      end

      // PLL lock status is set from the pin while the PLL is powered and held until a switch clears it
      if (sy_lvl[SY_PLL] && q_r.pll_en) begin
         q_nxt.lock = 1'b1;
      end

      // Switch sequencer; CPU enable is untouched here
      case (q_r.sw)
         SW_IDLE: begin
            if (q_r.sw_req) begin
               q_nxt.sw = SW_CHECK;
            end
         end
         SW_CHECK: begin
            if (q_r.req == q_r.cur) begin
               q_nxt.sw_req = 1'b0;
               q_nxt.sw = SW_IDLE;
            end else begin
               q_nxt.lock = 1'b0;
               q_nxt.cf = 1'b0;
               q_nxt.sw = SW_START;
            end
         end
         SW_START: begin
            if ((!is_crystal(q_r.req, q_r.psub) || sy_lvl[SY_OST]) &&
                (!uses_pll(q_r.req) || q_r.lock)) begin
               q_nxt.cnt = 4'h0;
               q_nxt.sw = SW_COUNT;
            end
         end
         SW_COUNT: begin
            if (new_edge) begin
               if (q_r.cnt == NEW_CLK_CYCLES - 4'h1) begin
                  q_nxt.cur = q_r.req;
                  q_nxt.sw_req = 1'b0;
                  q_nxt.sw = SW_IDLE;
               end else begin
                  q_nxt.cnt = q_r.cnt + 4'h1;
               end
            end
         end
         default: begin
            q_nxt.sw = SW_IDLE;
         end
      endcase

      // Fail-safe monitor, timed in low-power RC ticks
      if (sw_en && q_r.pw != PW_SLEEP && q_r.cur != SRC_LOW_POWER_RC_OSC) begin
         if (cur_edge) begin
            q_nxt.saw = 1'b1;
         end
         if (sy_tog[OSC_LOW_POWER_RC_OSC]) begin
            q_nxt.saw = 1'b0;
            if (q_r.saw || cur_edge) begin
               q_nxt.fcnt = 4'h0;
            end else if (q_r.fcnt == FAIL_LOW_POWER_RC_OSC_TICKS - 4'h1) begin
               fail_now = 1'b1;
            end else begin
               q_nxt.fcnt = q_r.fcnt + 4'h1;
            end
         end
      end else begin
         q_nxt.fcnt = 4'h0;
         q_nxt.saw = 1'b0;
      end
      if (fail_now) begin
         // Fallback beats any switch that is in flight
         q_nxt.trap = 1'b1;
         q_nxt.cf = 1'b1;
         q_nxt.cur = uses_pll(q_r.cur) ? SRC_INTERNAL_RC_WITH_PLL : SRC_FRC;
         q_nxt.sw = SW_IDLE;
         q_nxt.sw_req = 1'b0;
         q_nxt.fcnt = 4'h0;
      end

      // Configuration is caught on the reset cycles only
      if (rst) begin
         q_nxt = '0;
         q_nxt.sw_mon_cfg = switch_monitor_cfg;
         q_nxt.init_src = initial_source_cfg;
         q_nxt.psub = primary_submode_cfg;
         q_nxt.cur = initial_source_cfg;
         q_nxt.req = initial_source_cfg;
         q_nxt.sw = SW_IDLE;
         q_nxt.pw = PW_RUN;
      end

      // Derived clock controls, aligned with the registered state
      q_nxt.osc_en = src_osc(q_nxt.cur);
      q_nxt.pll_en = uses_pll(q_nxt.cur);
      if (q_nxt.sw == SW_START || q_nxt.sw == SW_COUNT) begin
         q_nxt.osc_en = q_nxt.osc_en | src_osc(q_nxt.req);
         q_nxt.pll_en = q_nxt.pll_en | uses_pll(q_nxt.req);
      end
      if (wdt_en || !q_nxt.sw_mon_cfg) begin
         q_nxt.osc_en[OSC_LOW_POWER_RC_OSC] = 1'b1;
      end
      q_nxt.cpu_en = (q_nxt.pw == PW_RUN);
      q_nxt.per_en = (q_nxt.pw != PW_SLEEP);
      q_nxt.sys_en = (q_nxt.pw != PW_SLEEP);
      if (q_nxt.pw == PW_SLEEP) begin
         q_nxt.osc_en = 4'h0;
         q_nxt.osc_en[OSC_LOW_POWER_RC_OSC] = wdt_en;
         q_nxt.pll_en = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      q_r <= q_nxt;
   end

   // ==========================================================
   // Outputs
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_rvalid = q_r.rvalid;
   assign s_axi_rresp = q_r.rresp;
   assign s_axi_rdata = q_r.rdata;
   assign sys_clk_sel = q_r.cur;
   assign osc_en = q_r.osc_en;
   assign pll_en = q_r.pll_en;
   assign cpu_clk_en = q_r.cpu_en;
   assign periph_clk_en = q_r.per_en;
   assign sys_clk_en = q_r.sys_en;
   assign wdt_clear = q_r.wdt_clr;
   assign clk_fail_trap = q_r.trap;
   assign primary_submode = q_r.psub;

   // ==========================================================
   // Checks
   a_swreq_when_off: assert property (
      @(posedge core_clk) disable iff (rst)
      !sw_en |-> !q_r.sw_req && q_r.cur == q_r.init_src)
      else $error("switch state moved while switching disabled");

   a_redundant_abort: assert property (
      @(posedge core_clk) disable iff (rst)
      (q_r.sw == SW_CHECK && q_r.req == q_r.cur)
      |=> q_r.sw == SW_IDLE && !q_r.sw_req)
      else $error("redundant switch not aborted");

   a_valid_clears: assert property (
      @(posedge core_clk) disable iff (rst)
      (q_r.sw == SW_CHECK && q_r.req != q_r.cur && !fail_now)
      |=> !q_r.cf && !q_r.lock && q_r.sw == SW_START)
      else $error("valid switch did not clear status flags");

   a_count_ten: assert property (
      @(posedge core_clk) disable iff (rst)
      (q_r.sw == SW_COUNT && q_nxt.sw == SW_IDLE && !fail_now)
      |-> q_r.cnt == 4'h9 && new_edge)
      else $error("changeover before ten new-clock cycles");

   a_done_copies: assert property (
      @(posedge core_clk) disable iff (rst)
      (q_r.sw == SW_COUNT && q_nxt.sw == SW_IDLE && !fail_now)
      |=> q_r.cur == $past(q_r.req) && !q_r.sw_req)
      else $error("completion did not copy source");

   a_fail_trap: assert property (
      @(posedge core_clk) disable iff (rst)
      fail_now |=> clk_fail_trap && q_r.cf &&
      (q_r.cur == SRC_FRC || q_r.cur == SRC_INTERNAL_RC_WITH_PLL) ##1 !clk_fail_trap)
      else $error("failure did not trap to internal RC");

   a_fail_pll: assert property (
      @(posedge core_clk) disable iff (rst)
      (fail_now && uses_pll(q_r.cur)) |=> q_r.cur == SRC_INTERNAL_RC_WITH_PLL)
      else $error("fallback dropped the PLL");

   a_sleep_gates: assert property (
      @(posedge core_clk) disable iff (rst)
      q_r.pw == PW_SLEEP |-> !sys_clk_en && !periph_clk_en &&
      osc_en[2:0] == 3'h0 && !pll_en && osc_en[OSC_LOW_POWER_RC_OSC] == $past(wdt_en))
      else $error("clocks running in sleep");

   a_idle_cpu: assert property (
      @(posedge core_clk) disable iff (rst)
      q_r.pw == PW_IDLE |-> !cpu_clk_en && sys_clk_en && periph_clk_en)
      else $error("idle clock gating wrong");

   a_wake_run: assert property (
      @(posedge core_clk) disable iff (rst)
      (q_r.pw != PW_RUN && (irq_pending || wdt_timeout) && !fail_now &&
       q_r.sw != SW_COUNT)
      |=> cpu_clk_en && $stable(sys_clk_sel))
      else $error("wake did not restore the CPU clock");

   a_cpu_switch: assert property (
      @(posedge core_clk) disable iff (rst)
      (q_r.sw != SW_IDLE && q_r.pw == PW_RUN) |-> cpu_clk_en)
      else $error("CPU stopped during switch");

endmodule : cspc_top

// ===== cspc_top_tb.sv
module cspc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cspc_pkg::*;

   // ==========================================================
   // Signals
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic [DATA_W-1:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DATA_W-1:0] s_axi_rdata;
   logic switch_monitor_cfg = 1'b0, wdt_en = 1'b1, irq_pending = 1'b0;
   logic wdt_timeout = 1'b0, pll_lock_pin = 1'b0;
   logic osc_startup_timer_done = 1'b1;
   logic [2:0] initial_source_cfg = SRC_FRC;
   logic [1:0] primary_submode_cfg = 2'h1;
   logic [3:0] osc_clk_toggle = 4'h0;
   logic [2:0] alive = 3'h7;
   logic [2:0] sys_clk_sel;
   logic [3:0] osc_en;
   logic pll_en, cpu_clk_en, periph_clk_en, sys_clk_en;
   logic wdt_clear, clk_fail_trap;
   logic [1:0] primary_submode;
   logic [31:0] rd;
   logic [1:0] rsp;
   int miscompares = 0, check_count = 0, cycles = 0, wclr = 0, traps = 0;
   int n;

   cspc_top DUT (
      .core_clk(core_clk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .switch_monitor_cfg(switch_monitor_cfg),
      .initial_source_cfg(initial_source_cfg),
      .primary_submode_cfg(primary_submode_cfg),
      .wdt_en(wdt_en),
      .irq_pending(irq_pending),
      .wdt_timeout(wdt_timeout),
      .osc_clk_toggle(osc_clk_toggle),
      .pll_lock_pin(pll_lock_pin),
      .osc_startup_timer_done(osc_startup_timer_done),
      .sys_clk_sel(sys_clk_sel),
      .osc_en(osc_en),
      .pll_en(pll_en),
      .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en),
      .sys_clk_en(sys_clk_en),
      .wdt_clear(wdt_clear),
      .clk_fail_trap(clk_fail_trap),
      .primary_submode(primary_submode)
   );

   initial forever #20 core_clk = ~core_clk;

   // Oscillator pins run free and unrelated to core_clk; a dead one stops
   always #67.3 osc_clk_toggle[2:0] <= osc_clk_toggle[2:0] ^ alive;
   always #517.1 osc_clk_toggle[3] <= ~osc_clk_toggle[3];

   always @(posedge core_clk) begin
      cycles++;
      if (wdt_clear === 1'b1) wclr++;
      if (clk_fail_trap === 1'b1) traps++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ==========================================================
   // Common tasks
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(negedge core_clk);
      while (s_axi_awready !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(negedge core_clk);
      while (s_axi_bvalid !== 1'b1) @(negedge core_clk);
      rsp = s_axi_bresp;
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge core_clk);
      while (s_axi_arready !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      @(negedge core_clk);
      while (s_axi_rvalid !== 1'b1) @(negedge core_clk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // Source code first, switch bit second, fail flag written as 1 to keep it
   task automatic do_switch(input logic [2:0] src);
      axi_wr(OSC_CTRL_OFS, 32'(src) << REQ_SRC_LSB, 4'h2);
      axi_wr(OSC_CTRL_OFS, 32'h9, 4'h1);
   endtask : do_switch

   task automatic wait_sel(input logic [2:0] e);
      n = 0;
      while (sys_clk_sel !== e && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      chk("sys_clk_sel", e, sys_clk_sel);
   endtask : wait_sel

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk("sel", SRC_FRC, sys_clk_sel);
      chk("osc_en", 4'h9, osc_en);
      chk("pll_en", 1'b0, pll_en);
      chk("submode", 2'h1, primary_submode);
      axi_rd(CFG_STAT_OFS);
      chk("cfg", 32'h3, rd);
      // Watchdog off: the monitor alone must keep the RC running
      @(posedge core_clk);
      wdt_en <= 1'b0;
      cyc(2);
      chk("low_power_rc_osc mon", 4'h9, osc_en);
      @(posedge core_clk);
      wdt_en <= 1'b1;
      cyc(1);
   endtask : t_reset

   task automatic t_redundant();
      do_switch(SRC_FRC);
      cyc(20);
      axi_rd(OSC_CTRL_OFS);
      chk("swreq", 1'b0, rd[SWREQ_BIT]);
      chk("cur", SRC_FRC, rd[14:12]);
   endtask : t_redundant

   task automatic t_primary();
      do_switch(SRC_PRI);
      wait_sel(SRC_PRI);
      chk("ten new cycles", 1'b1, n >= 12);
      chk("cpu run", 1'b1, cpu_clk_en);
      axi_rd(OSC_CTRL_OFS);
      chk("swreq", 1'b0, rd[SWREQ_BIT]);
      chk("cur", SRC_PRI, rd[14:12]);
      chk("osc_en", 4'hA, osc_en);
   endtask : t_primary

   task automatic t_pll();
      do_switch(SRC_PRIPLL);
      cyc(60);
      chk("sel unlocked", SRC_PRI, sys_clk_sel);
      axi_rd(OSC_CTRL_OFS);
      chk("swreq pend", 1'b1, rd[SWREQ_BIT]);
      @(posedge core_clk);
      pll_lock_pin <= 1'b1;
      wait_sel(SRC_PRIPLL);
      axi_rd(OSC_CTRL_OFS);
      chk("lock", 1'b1, rd[LOCK_BIT]);
      chk("pll_en", 1'b1, pll_en);
   endtask : t_pll

   task automatic t_fail();
      int t0;
      t0 = traps;
      alive[1] <= 1'b0;
      n = 0;
      while (traps == t0 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      cyc(2);
      chk("trap", 1, traps - t0);
      chk("sel", SRC_INTERNAL_RC_WITH_PLL, sys_clk_sel);
      axi_rd(OSC_CTRL_OFS);
      chk("cf set", 1'b1, rd[CF_BIT]);
      axi_wr(OSC_CTRL_OFS, 32'h0, 4'h1);
      axi_rd(OSC_CTRL_OFS);
      chk("cf clr", 1'b0, rd[CF_BIT]);
      alive[1] <= 1'b1;
      do_switch(SRC_FRC);
      wait_sel(SRC_FRC);
      chk("pll off", 1'b0, pll_en);
   endtask : t_fail

   task automatic t_sleep();
      int w0;
      w0 = wclr;
      axi_wr(PWR_CTRL_OFS, 32'h1, 4'h1);
      cyc(1);
      chk("cpu", 1'b0, cpu_clk_en);
      chk("sys", 1'b0, sys_clk_en);
      chk("periph", 1'b0, periph_clk_en);
      chk("osc_en", 4'h8, osc_en);
      chk("wdt clr", 1, wclr - w0);
      @(posedge core_clk);
      irq_pending <= 1'b1;
      cyc(3);
      chk("cpu", 1'b1, cpu_clk_en);
      chk("sys", 1'b1, sys_clk_en);
      chk("sel", SRC_FRC, sys_clk_sel);
      @(posedge core_clk);
      irq_pending <= 1'b0;
   endtask : t_sleep

   task automatic t_idle();
      int w0;
      w0 = wclr;
      axi_wr(PWR_CTRL_OFS, 32'h2, 4'h1);
      cyc(1);
      chk("cpu", 1'b0, cpu_clk_en);
      chk("periph", 1'b1, periph_clk_en);
      chk("sys", 1'b1, sys_clk_en);
      chk("osc_en", 4'h9, osc_en);
      chk("wdt clr", 1, wclr - w0);
      @(posedge core_clk);
      wdt_timeout <= 1'b1;
      @(posedge core_clk);
      wdt_timeout <= 1'b0;
      cyc(2);
      chk("cpu", 1'b1, cpu_clk_en);
   endtask : t_idle

   task automatic t_unmapped();
      axi_rd(8'h10);
      chk("rresp", RESP_SLVERR, rsp);
      chk("rdata", 32'h0, rd);
      axi_wr(8'h10, 32'hFFFFFFFF, 4'hF);
      chk("bresp", RESP_SLVERR, rsp);
   endtask : t_unmapped

   // Monitor and switching both off: dead primary must go unnoticed
   task automatic t_disabled();
      int t0;
      @(posedge core_clk);
      switch_monitor_cfg <= 1'b1;
      initial_source_cfg <= SRC_PRI;
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      cyc(1);
      chk("sel", SRC_PRI, sys_clk_sel);
      axi_rd(CFG_STAT_OFS);
      chk("cfg", 32'h22, rd);
      do_switch(SRC_FRC);
      cyc(40);
      axi_rd(OSC_CTRL_OFS);
      chk("swreq", 1'b0, rd[SWREQ_BIT]);
      chk("cur", SRC_PRI, rd[14:12]);
      t0 = traps;
      alive[1] <= 1'b0;
      cyc(150);
      chk("no trap", t0, traps);
      chk("sel", SRC_PRI, sys_clk_sel);
      alive[1] <= 1'b1;
      // Neither watchdog nor monitor: the RC may stop
      @(posedge core_clk);
      wdt_en <= 1'b0;
      cyc(2);
      chk("low_power_rc_osc off", 4'h2, osc_en);
   endtask : t_disabled

   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      cyc(1);
      t_reset();
      t_redundant();
      t_primary();
      t_pll();
      t_fail();
      t_sleep();
      t_idle();
      t_unmapped();
      t_disabled();
      test_done();
   end
endmodule : cspc_top_tb
